// >>> logic/dav_motion_outputs.sv
// Integrated rotation and speed change outputs with register read port
//
// Summary of operation
// RULE1: Z rotation increment readable as low word 0x2C, high word 0x2E.
// RULE2: Rotation high word is twos complement, zero is 0x0000.
// RULE3: Sum of each sample plus previous sample, times one over 2fs.
// RULE4: Each output accumulates decimation setting plus one samples.
// RULE5: Internal sample clock gives a nominal 2000 samples per second.
// RULE6: Speed change low words at 0x30, 0x34, 0x38, high words follow.
// RULE7: Speed change high word twos complement, 100 m/s over 2^15 per count.
// RULE8: High and low word form one 32-bit twos complement value.
// RULE9: 32-bit full scale codes are 0x7FFFFFFF and 0x80000000.
// RULE10: 16-bit codes run from 0x8000 up to 0x7FFF.
// RULE11: Plus one count is 0x0001, minus one is 0xFFFF.
// RULE12: Each result is the change since the previous update only.
// RULE13: User bias follows factory correction; chain runs at 2000 Hz.
// RULE14: Bias adjustable per sensor; factory formulas stay hidden.
// RULE15: Host may rescale results by measured ready pin rate.
// RULE16: Rotation uses the same trapezoid on gyro rate samples.
// RULE17: Rotation full scale is 360, 720 or 2160 degrees by model.
// RULE18: Accumulator restarts each period; words come from one update.
`timescale 1ns/1ps
module dav_motion_outputs import dav_pkg::*; #(
    parameter int SAMPLE_DIV = DAV_SAMPLE_DIV,
    parameter int DEC_W = 16,
    parameter int ACC_W = 48
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire dav_axis_set_t factory_samples,
    input wire dav_axis_set_t user_bias,
    input wire logic [DEC_W-1:0] output_decimation_setting,
    input wire dav_read_req_t read_req,
    output logic [15:0] read_data,
    output logic read_valid,
    output logic sample_ready_pin
);

    localparam int DIV_W = (SAMPLE_DIV > 1) ? $clog2(SAMPLE_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);

    logic [DIV_W-1:0] div_cnt_reg;
    logic [DIV_W-1:0] div_cnt_next;
    logic [DEC_W-1:0] dec_cnt_reg;
    logic [DEC_W-1:0] dec_cnt_next;
    logic ready_reg;
    logic ready_next;
    logic [15:0] rd_data_reg;
    logic [15:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic tick;
    logic last;
    logic [31:0] zrot_word;
    logic [31:0] xspd_word;
    logic [31:0] yspd_word;
    logic [31:0] zspd_word;

    always_comb begin
        // RULE5: 2000 SPS sample enable
        tick = (div_cnt_reg == DIV_LAST);
        div_cnt_next = tick ? '0 : div_cnt_reg + 1'b1;
        // RULE4: setting plus one samples
        // Compare with >= so lowering the setting mid-period cannot stall
        last = (dec_cnt_reg >= output_decimation_setting);
        dec_cnt_next = dec_cnt_reg;
        if (tick) begin
            dec_cnt_next = last ? '0 : dec_cnt_reg + 1'b1;
        end
        // Ready pulse marks the cycle the new results become readable
        ready_next = tick & last;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_cnt_reg <= '0;
            dec_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            dec_cnt_reg <= dec_cnt_next;
            ready_reg <= ready_next;
        end
    end

    // RULE16: gyro uses trapezoid
    // RULE17: range scales inputs only
    // The model's rotation range only rescales the input units; no logic
    dav_trap_integrator #(.ACC_W(ACC_W)) u_zrot (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick),
        .last(last),
        .sample_in(factory_samples.gyro_z),
        .bias_in(user_bias.gyro_z),
        .result(zrot_word)
    );

    // RULE14: per sensor bias
    dav_trap_integrator #(.ACC_W(ACC_W)) u_xspd (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick),
        .last(last),
        .sample_in(factory_samples.accel_x),
        .bias_in(user_bias.accel_x),
        .result(xspd_word)
    );

    dav_trap_integrator #(.ACC_W(ACC_W)) u_yspd (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick),
        .last(last),
        .sample_in(factory_samples.accel_y),
        .bias_in(user_bias.accel_y),
        .result(yspd_word)
    );

    dav_trap_integrator #(.ACC_W(ACC_W)) u_zspd (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick),
        .last(last),
        .sample_in(factory_samples.accel_z),
        .bias_in(user_bias.accel_z),
        .result(zspd_word)
    );

    always_comb begin
        rd_valid_next = read_req.en;
        rd_data_next = rd_data_reg;
        if (read_req.en) begin
            // RULE8: high word upper half
            // RULE18: halves share update
            // Both halves live in one register, but two separate reads that straddle an update can tear a pair
            case ({read_req.addr[6:1], 1'b0})
                // RULE1: rotation word offsets
                DAV_ADDR_ZROT_LOW: rd_data_next = zrot_word[15:0];
                // RULE2: twos complement high
                DAV_ADDR_ZROT_HIGH: rd_data_next = zrot_word[31:16];
                // RULE6: speed word offsets
                DAV_ADDR_XSPD_LOW: rd_data_next = xspd_word[15:0];
                // RULE7: speed high word
                // RULE10: sixteen bit codes
                DAV_ADDR_XSPD_HIGH: rd_data_next = xspd_word[31:16];
                DAV_ADDR_YSPD_LOW: rd_data_next = yspd_word[15:0];
                DAV_ADDR_YSPD_HIGH: rd_data_next = yspd_word[31:16];
                DAV_ADDR_ZSPD_LOW: rd_data_next = zspd_word[15:0];
                DAV_ADDR_ZSPD_HIGH: rd_data_next = zspd_word[31:16];
                default: rd_data_next = DAV_UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data_reg <= DAV_UNMAPPED_DATA;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign read_data = rd_data_reg;
    assign read_valid = rd_valid_reg;
    assign sample_ready_pin = ready_reg;

endmodule : dav_motion_outputs

// >>> logic/dav_pkg.sv
// Shared constants and types of the integrated motion output block
package dav_pkg;

    // Register byte addresses; each word also answers at its odd address
    localparam logic [6:0] DAV_ADDR_ZROT_LOW = 7'h2C;
    localparam logic [6:0] DAV_ADDR_ZROT_HIGH = 7'h2E;
    localparam logic [6:0] DAV_ADDR_XSPD_LOW = 7'h30;
    localparam logic [6:0] DAV_ADDR_XSPD_HIGH = 7'h32;
    localparam logic [6:0] DAV_ADDR_YSPD_LOW = 7'h34;
    localparam logic [6:0] DAV_ADDR_YSPD_HIGH = 7'h36;
    localparam logic [6:0] DAV_ADDR_ZSPD_LOW = 7'h38;
    localparam logic [6:0] DAV_ADDR_ZSPD_HIGH = 7'h3A;

    // Output values before the first update and on unmapped reads
    localparam logic [31:0] DAV_RESULT_RESET = 32'h0000_0000;
    localparam logic [15:0] DAV_UNMAPPED_DATA = 16'h0000;

    // Saturation limits of the 32-bit result
    localparam logic [31:0] DAV_POS_FULL = 32'h7FFF_FFFF;
    localparam logic [31:0] DAV_NEG_FULL = 32'h8000_0000;

    // Sample timing: nominal internal sample rate
    localparam int DAV_CLK_HZ = 200_000_000;
    localparam int DAV_SAMPLE_RATE_SPS = 2000;
    localparam int DAV_SAMPLE_DIV = DAV_CLK_HZ / DAV_SAMPLE_RATE_SPS;

    // One set of per-axis values: z rotation rate and x/y/z acceleration
    typedef struct packed {
        logic signed [31:0] gyro_z;
        logic signed [31:0] accel_x;
        logic signed [31:0] accel_y;
        logic signed [31:0] accel_z;
    } dav_axis_set_t;

    // Register read request from the serial interface logic
    typedef struct packed {
        logic en;
        logic [6:0] addr;
    } dav_read_req_t;

endpackage : dav_pkg

// >>> logic/dav_trap_integrator.sv
// Trapezoidal integrator for one axis with user bias and saturation
`timescale 1ns/1ps
module dav_trap_integrator import dav_pkg::*; #(
    parameter int ACC_W = 48
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic last,
    input wire logic signed [31:0] sample_in,
    input wire logic signed [31:0] bias_in,
    output logic [31:0] result
);

    logic signed [ACC_W-1:0] acc_reg;
    logic signed [ACC_W-1:0] acc_next;
    logic signed [31:0] prev_reg;
    logic signed [31:0] prev_next;
    logic [31:0] result_reg;
    logic [31:0] result_next;
    logic signed [32:0] corr_wide;
    logic signed [31:0] corr;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] half;
    logic signed [ACC_W-1:0] pos_lim;
    logic signed [ACC_W-1:0] neg_lim;

    always_comb begin
        // RULE13: bias after factory
        corr_wide = {sample_in[31], sample_in} + {bias_in[31], bias_in};
        // Saturate so a large bias cannot wrap the sample sign
        if (corr_wide[32] != corr_wide[31]) begin
            corr = corr_wide[32] ? $signed(DAV_NEG_FULL)
                                 : $signed(DAV_POS_FULL);
        end else begin
            corr = corr_wide[31:0];
        end
        // RULE3: sample plus previous
        sum = acc_reg + {{(ACC_W-32){corr[31]}}, corr}
            + {{(ACC_W-32){prev_reg[31]}}, prev_reg};
        // The factor one half of the trapezoid
        half = sum >>> 1;
        pos_lim = {{(ACC_W-32){1'b0}}, DAV_POS_FULL};
        neg_lim = {{(ACC_W-32){1'b1}}, DAV_NEG_FULL};
        acc_next = acc_reg;
        prev_next = prev_reg;
        result_next = result_reg;
        if (tick) begin
            prev_next = corr;
            acc_next = sum;
            if (last) begin
                // RULE9: clamp to full scale
                if (half > pos_lim) begin
                    result_next = DAV_POS_FULL;
                end else if (half < neg_lim) begin
                    result_next = DAV_NEG_FULL;
                end else begin
                    // RULE11: twos complement order
                    result_next = half[31:0];
                end
                // RULE12: restart per period
                acc_next = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acc_reg <= '0;
            prev_reg <= '0;
            result_reg <= DAV_RESULT_RESET;
        end else begin
            acc_reg <= acc_next;
            prev_reg <= prev_next;
            result_reg <= result_next;
        end
    end

    assign result = result_reg;

endmodule : dav_trap_integrator

// >>> test/dav_asserts.sv
// Port checks of the integrated motion output block
`timescale 1ns/1ps
module dav_asserts import dav_pkg::*; #(
    parameter int SAMPLE_DIV = DAV_SAMPLE_DIV
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire dav_read_req_t read_req,
    input wire logic [15:0] read_data,
    input wire logic read_valid,
    input wire logic sample_ready_pin
);
    int gap_reg;
    int gap_next;
    logic seen_reg;
    logic seen_next;
    logic unmapped;
    assign unmapped = read_req.addr < 7'h2C || read_req.addr > 7'h3B;
    // Gap restarts at one so it equals the pulse spacing
    always_comb begin
        gap_next = sample_ready_pin ? 1 : gap_reg + 1;
        seen_next = seen_reg | sample_ready_pin;
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gap_reg <= 0;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= gap_next;
            seen_reg <= seen_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence pulse_s;
        sample_ready_pin ##1 !sample_ready_pin;
    endsequence
    rd_answer_a: assert property (
        read_req.en |=> read_valid) else $error("read not answered");
    rd_quiet_a: assert property (
        !read_req.en |=> !read_valid) else $error("answer without read");
    unmapped_zero_a: assert property (
        read_req.en && unmapped |=> read_data == 16'h0000)
        else $error("unmapped read not zero");
    rd_hold_a: assert property (
        !read_req.en |=> $stable(read_data)) else $error("read data moved");
    pin_pulse_a: assert property (
        sample_ready_pin |-> pulse_s) else $error("ready pulse too long");
    pin_gap_a: assert property (
        sample_ready_pin && seen_reg |-> gap_reg >= SAMPLE_DIV
        && gap_reg % SAMPLE_DIV == 0) else $error("ready spacing wrong");
    reset_quiet_a: assert property (
        $rose(rst_b) |-> !sample_ready_pin [*8])
        else $error("ready pulse too soon");
    zero_before_a: assert property (
        read_req.en && !seen_reg && !sample_ready_pin |=> read_data == 16'h0000)
        else $error("nonzero before first update");
endmodule : dav_asserts

// >>> test/dav_host_model.sv
// Host side model that reads the output registers
`timescale 1ns/1ps
module dav_host_model import dav_pkg::*; (
    input wire logic clk,
    input wire logic [15:0] read_data,
    input wire logic read_valid,
    output dav_read_req_t read_req
);
    initial read_req = '0;
    // nominal rate assumed, so no rescaling of results
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        int n;
        @(negedge clk);
        read_req.en = 1'b1;
        read_req.addr = a;
        @(negedge clk);
        read_req.en = 1'b0;
        read_req.addr = ~a;
        n = 0;
        while (read_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        d = read_data;
    endtask : rd
endmodule : dav_host_model

// >>> test/test_dav_motion_outputs.sv
// Self-checking bench of the integrated motion output block
`timescale 1ns/1ps
module test_dav_motion_outputs;
    import dav_pkg::*;
    localparam int SD = 32;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    // Bias on x pushes its corrected sample from 2 to 3
    dav_axis_set_t smp = {32'h5, 32'h2, 32'hFFFF_FFFF, 32'h4000_0000};
    dav_axis_set_t bias = {32'h0, 32'h1, 32'h0, 32'h0};
    logic [15:0] dec = 16'h0001;
    dav_read_req_t read_req;
    logic [15:0] read_data;
    logic read_valid;
    logic pin;
    int mismatches = 0;
    int cmp_count = 0;
    always #2.5 clk = ~clk;
    dav_motion_outputs #(.SAMPLE_DIV(SD)) dut (.clk(clk), .rst_b(rst_b),
        .factory_samples(smp), .user_bias(bias),
        .output_decimation_setting(dec), .read_req(read_req),
        .read_data(read_data), .read_valid(read_valid),
        .sample_ready_pin(pin));
    dav_host_model host (.clk(clk), .read_data(read_data),
        .read_valid(read_valid), .read_req(read_req));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic check_all(input logic [31:0] e [4]);
        logic [15:0] lo;
        logic [15:0] hi;
        for (int i = 0; i < 4; i++) begin
            host.rd(7'(7'h2C + 4 * i), lo);
            host.rd(7'(7'h2E + 4 * i), hi);
            check({hi, lo}, e[i]);
        end
    endtask : check_all
    task automatic wait_pin();
        int n;
        n = 0;
        while (pin !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check(32'(n < 300), 32'h1);
    endtask : wait_pin
    task automatic test_reset();
        logic [15:0] w;
        check_all('{32'h0, 32'h0, 32'h0, 32'h0});
        host.rd(7'h3C, w);
        check(32'(w), 32'h0);
        $display("reset test done");
    endtask : test_reset
    // Second period would give 3.5 times the corrected sample, not twice it, if the sum ran on
    task automatic test_periods();
        wait_pin();
        check_all('{32'h7, 32'h4, 32'hFFFF_FFFE, 32'h6000_0000});
        wait_pin();
        check_all('{32'hA, 32'h6, 32'hFFFF_FFFE, 32'h7FFF_FFFF});
        $display("period test done");
    endtask : test_periods
    task automatic test_decim();
        @(negedge clk);
        dec = 16'h0000;
        wait_pin();
        check_all('{32'h5, 32'h3, 32'hFFFF_FFFF, 32'h4000_0000});
        $display("decimation test done");
    endtask : test_decim
    // Biased samples beyond 32 bits must saturate, not wrap their sign
    task automatic test_limits();
        logic [15:0] w;
        wait_pin();
        smp = {32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h1, 32'h8000_0000};
        bias = {32'h0, 32'h1, 32'h0, 32'hFFFF_FFFF};
        repeat (2) begin
            @(negedge clk);
            wait_pin();
        end
        check_all('{32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h1,
            32'h8000_0000});
        host.rd(7'h2F, w);
        check(32'(w), 32'h0000_FFFF);
        $display("limit test done");
    endtask : test_limits
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        test_reset();
        test_periods();
        test_decim();
        test_limits();
        final_report();
    end
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
endmodule : test_dav_motion_outputs
bind dav_motion_outputs dav_asserts #(.SAMPLE_DIV(SAMPLE_DIV)) chk (
    .clk(clk), .rst_b(rst_b), .read_req(read_req), .read_data(read_data),
    .read_valid(read_valid), .sample_ready_pin(sample_ready_pin));
